// file: hdl/eatu_pkg.sv
// Package for the effective address and transfer unit.
// Assumes a 36-bit word, position 0 at the msb, held as index 35 - position.
package eatu_pkg;
	// ****************************************
	// Word layout
	// ****************************************
	localparam int unsigned ADDR_W      = 15;
	localparam int unsigned WORD_W      = 36;
	localparam int unsigned NUM_XR      = 3;
	localparam int unsigned BASE_LSB    = 0;
	localparam int unsigned TAG_LSB     = 15;
	localparam int unsigned DEC_LSB     = 18;
	localparam int unsigned IND_HI_BIT  = 23;
	localparam int unsigned IND_LO_BIT  = 22;
	localparam int unsigned OP_LSB      = 33;

	// ****************************************
	// Reset values and register offsets
	// ****************************************
	localparam logic [14:0] IC_RST      = 15'h0000;
	localparam logic [14:0] XR_RST      = 15'h0000;
	localparam logic [14:0] ADDR_ONE    = 15'h0001;
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_IC      = 8'h04;
	localparam logic [7:0]  OFS_STATUS  = 8'h08;
	localparam logic [7:0]  OFS_EA      = 8'h0C;
	localparam logic [7:0]  OFS_XR_BASE = 8'h10;

	typedef enum logic [2:0] {
		OP_MEMREF = 3'h0,
		OP_TRA    = 3'h1,
		OP_TRC    = 3'h2,
		OP_TSX    = 3'h3,
		OP_STXA   = 3'h4,
		OP_STXD   = 3'h5,
		OP_TSR    = 3'h6,
		OP_HALT   = 3'h7
	} eatu_op_t;

	typedef enum logic [3:0] {
		S_IDLE  = 4'h0,
		S_FETCH = 4'h1,
		S_DEC   = 4'h2,
		S_IND   = 4'h3,
		S_INDX  = 4'h4,
		S_EXEC  = 4'h5,
		S_WWAIT = 4'h6,
		S_TSX1  = 4'h7,
		S_TSX2  = 4'h8,
		S_TSX3  = 4'h9
	} eatu_state_t;

	typedef logic [2:0][14:0] eatu_xr_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [14:0] addr;
		logic [35:0] wdata;
	} eatu_mem_req_t;
endpackage : eatu_pkg

// file: hdl/eatu_addr_adder.sv
// Address adder: a plus ones complement of b plus a forced carry.
// Purely combinational; the caller registers the sum.
`timescale 1ns/1ns
`default_nettype none
module eatu_addr_adder (
	input  wire logic [14:0] a_in,
	input  wire logic [14:0] b_in,
	output logic      [14:0] sum_out
);
	assign sum_out = 15'(a_in + ~b_in + 15'h0001);
endmodule : eatu_addr_adder
`default_nettype wire

// file: hdl/eatu_index_select.sv
// Index register selection by a three-bit tag.
// Assumes tag bit 0 picks the first register, bit 2 the third.
`timescale 1ns/1ns
`default_nettype none
module eatu_index_select (
	input  wire logic [2:0]       tag_in,
	input  wire eatu_pkg::eatu_xr_t xr_in,
	output logic      [14:0]      or_out
);
	logic [2:0][14:0] masked;

	genvar k;
	for (k = 0; k < 3; k++) begin : g_mask
		assign masked[k] = tag_in[k] ? xr_in[k] : 15'h0000;
	end

	assign or_out = masked[0] | masked[1] | masked[2];
endmodule : eatu_index_select
`default_nettype wire

// file: hdl/eatu_core.sv
// Effective address formation and instruction sequencing.
// Assumes core storage answers each request with one mem_ack_in pulse, data beside it.
`timescale 1ns/1ns
`default_nettype none
module eatu_core (
	input  wire logic                    ref_clk_in,
	input  wire logic                    resetn_in,
	input  wire logic [7:0]              reg_addr_in,
	input  wire logic [31:0]             reg_wdata_in,
	input  wire logic                    reg_wr_in,
	input  wire logic                    reg_rd_in,
	output logic      [31:0]             reg_rdata_out,
	output var eatu_pkg::eatu_mem_req_t  mem_req_out,
	input  wire logic                    mem_ack_in,
	input  wire logic [35:0]             mem_rdata_in,
	input  wire logic                    cond_in,
	output logic      [14:0]             ea_out,
	output logic                         ea_valid_out
);
	// ****************************************
	// State
	// ****************************************
	eatu_pkg::eatu_state_t   state, next_state;
	eatu_pkg::eatu_mem_req_t mem_q, next_mem;
	eatu_pkg::eatu_xr_t      xr, next_xr;
	logic [14:0] ic, next_ic;
	logic [14:0] ar, next_ar;
	logic [14:0] index_input_buffer, next_index_input_buffer;
	logic [14:0] ea, next_ea;
	logic [35:0] ir, next_ir;
	logic [35:0] sr, next_sr;
	logic        run, next_run;
	logic        ea_vld, next_ea_vld;
	logic [31:0] rdata, next_rdata;

	eatu_pkg::eatu_op_t op;
	logic        indirect;
	logic        no_index;
	logic [2:0]  add_tag;
	logic [14:0] add_a, add_b, sum, sel_ir;

	assign op       = eatu_pkg::eatu_op_t'(ir[35:eatu_pkg::OP_LSB]);
	// only the instruction's own flag bits
	assign indirect = ir[eatu_pkg::IND_HI_BIT] & ir[eatu_pkg::IND_LO_BIT];
	// tag names the register to load or store, so no indexing
	assign no_index = (op == eatu_pkg::OP_TSX) || (op == eatu_pkg::OP_STXA) ||
	                  (op == eatu_pkg::OP_STXD);

	// ****************************************
	// Adder operand steering
	// ****************************************
	always_comb begin
		add_a   = ir[14:0];
		add_tag = ir[17:15];
		case (state)
			eatu_pkg::S_DEC: begin
				add_a   = ir[14:0];
				add_tag = no_index ? 3'h0 : ir[17:15];
			end
			eatu_pkg::S_INDX: begin
				// indirect word indexed by its tag
				add_a   = sr[14:0];
				add_tag = sr[17:15];
			end
			eatu_pkg::S_EXEC: begin
				add_a   = ic;
				add_tag = 3'h0;
			end
			eatu_pkg::S_TSX2: begin
				// zero minus register is twos complement
				add_a   = 15'h0000;
				add_tag = ir[17:15];
			end
			default: begin
				add_a   = ir[14:0];
				add_tag = ir[17:15];
			end
		endcase
	end

	eatu_index_select u_sel_add (
		.tag_in (add_tag),
		.xr_in  (xr),
		.or_out (add_b)
	);

	eatu_index_select u_sel_ir (
		.tag_in (ir[17:15]),
		.xr_in  (xr),
		.or_out (sel_ir)
	);

	eatu_addr_adder u_adder (
		.a_in    (add_a),
		.b_in    (add_b),
		.sum_out (sum)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_state              = state;
		next_mem                = mem_q;
		next_xr                 = xr;
		next_ic                 = ic;
		next_ar                 = ar;
		next_index_input_buffer = index_input_buffer;
		next_ea                 = ea;
		next_ir                 = ir;
		next_sr                 = sr;
		next_run                = run;
		next_ea_vld             = 1'b0;
		next_rdata              = 32'h0000_0000;
		if (mem_ack_in) begin
			next_mem.rd = 1'b0;
			next_mem.wr = 1'b0;
		end
		case (state)
			eatu_pkg::S_IDLE: begin
				if (run) begin
					next_mem.rd   = 1'b1;
					next_mem.addr = ic;
					next_state    = eatu_pkg::S_FETCH;
				end
			end
			eatu_pkg::S_FETCH: begin
				if (mem_ack_in) begin
					next_ir    = mem_rdata_in;
					next_sr    = mem_rdata_in;
					next_state = eatu_pkg::S_DEC;
				end
			end
			eatu_pkg::S_DEC: begin
				if (indirect && op != eatu_pkg::OP_TSX) begin
					next_mem.rd   = 1'b1;
					next_mem.addr = sum;
					next_state    = eatu_pkg::S_IND;
				end else begin
					next_ar    = sum;
					next_state = eatu_pkg::S_EXEC;
				end
			end
			eatu_pkg::S_IND: begin
				// keep only tag and address fields
				if (mem_ack_in) begin
					next_sr    = {18'h00000, mem_rdata_in[17:0]};
					next_state = eatu_pkg::S_INDX;
				end
			end
			eatu_pkg::S_INDX: begin
				next_ar    = sum;
				next_state = eatu_pkg::S_EXEC;
			end
			eatu_pkg::S_EXEC: begin
				next_state = eatu_pkg::S_IDLE;
				next_ic    = 15'(ic + eatu_pkg::ADDR_ONE);
				case (op)
					eatu_pkg::OP_MEMREF: begin
						next_ea     = ar;
						next_ea_vld = 1'b1;
					end
					eatu_pkg::OP_TRA: next_ic = ar;
					eatu_pkg::OP_TRC: next_ic = cond_in ? ar : 15'(ic + eatu_pkg::ADDR_ONE);
					eatu_pkg::OP_TSX: begin
						next_ic                 = ic;
						next_index_input_buffer = sum;
						next_state              = eatu_pkg::S_TSX1;
					end
					eatu_pkg::OP_STXA, eatu_pkg::OP_STXD: begin
						next_ic        = ic;
						next_sr        = (op == eatu_pkg::OP_STXA) ?
						                 {21'h000000, sel_ir} : {3'h0, sel_ir, 18'h00000};
						next_mem.wr    = 1'b1;
						next_mem.addr  = ar;
						next_mem.wdata = next_sr;
						next_state     = eatu_pkg::S_WWAIT;
					end
					eatu_pkg::OP_TSR: begin
						next_ic        = ar;
						next_sr        = {21'h000000, 15'(ic + eatu_pkg::ADDR_ONE)};
						next_mem.wr    = 1'b1;
						next_mem.addr  = ar;
						next_mem.wdata = next_sr;
						next_state     = eatu_pkg::S_WWAIT;
					end
					eatu_pkg::OP_HALT: next_run = 1'b0;
					default: next_state = eatu_pkg::S_IDLE;
				endcase
			end
			eatu_pkg::S_WWAIT: begin
				if (mem_ack_in) begin
					next_ic    = 15'(ic + eatu_pkg::ADDR_ONE);
					next_state = eatu_pkg::S_IDLE;
				end
			end
			eatu_pkg::S_TSX1: begin
				for (int k = 0; k < 3; k++) begin
					if (ir[eatu_pkg::TAG_LSB + k]) begin
						next_xr[k] = index_input_buffer;
					end
				end
				next_state = eatu_pkg::S_TSX2;
			end
			eatu_pkg::S_TSX2: begin
				next_index_input_buffer = sum;
				next_state              = eatu_pkg::S_TSX3;
			end
			eatu_pkg::S_TSX3: begin
				for (int k = 0; k < 3; k++) begin
					if (ir[eatu_pkg::TAG_LSB + k]) begin
						next_xr[k] = index_input_buffer;
					end
				end
				next_ic    = ar;
				next_state = eatu_pkg::S_IDLE;
			end
			default: next_state = eatu_pkg::S_IDLE;
		endcase

		// IC and index loads only while the run bit is clear, which can be before the current instruction ends
		if (reg_wr_in) begin
			if (reg_addr_in == eatu_pkg::OFS_CTRL) begin
				next_run = reg_wdata_in[0];
			end else if (!run && reg_addr_in == eatu_pkg::OFS_IC) begin
				next_ic = reg_wdata_in[14:0];
			end else if (!run) begin
				for (int k = 0; k < 3; k++) begin
					if (reg_addr_in == 8'(eatu_pkg::OFS_XR_BASE + 8'(4 * k))) begin
						next_xr[k] = reg_wdata_in[14:0];
					end
				end
			end
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				eatu_pkg::OFS_CTRL:   next_rdata = {31'h00000000, run};
				eatu_pkg::OFS_IC:     next_rdata = {17'h00000, ic};
				eatu_pkg::OFS_STATUS: next_rdata = {27'h0000000, state != eatu_pkg::S_IDLE, state};
				eatu_pkg::OFS_EA:     next_rdata = {17'h00000, ea};
				8'h10:                next_rdata = {17'h00000, xr[0]};
				8'h14:                next_rdata = {17'h00000, xr[1]};
				8'h18:                next_rdata = {17'h00000, xr[2]};
				default:              next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state              <= eatu_pkg::S_IDLE;
			mem_q              <= '0;
			xr                 <= {eatu_pkg::XR_RST, eatu_pkg::XR_RST, eatu_pkg::XR_RST};
			ic                 <= eatu_pkg::IC_RST;
			ar                 <= 15'h0000;
			index_input_buffer <= 15'h0000;
			ea                 <= 15'h0000;
			ir                 <= 36'h0_0000_0000;
			sr                 <= 36'h0_0000_0000;
			run                <= 1'b0;
			ea_vld             <= 1'b0;
			rdata              <= 32'h0000_0000;
		end else begin
			state              <= next_state;
			mem_q              <= next_mem;
			xr                 <= next_xr;
			ic                 <= next_ic;
			ar                 <= next_ar;
			index_input_buffer <= next_index_input_buffer;
			ea                 <= next_ea;
			ir                 <= next_ir;
			sr                 <= next_sr;
			run                <= next_run;
			ea_vld             <= next_ea_vld;
			rdata              <= next_rdata;
		end
	end

	assign mem_req_out   = mem_q;
	assign reg_rdata_out = rdata;
	assign ea_out        = ea;
	assign ea_valid_out  = ea_vld;

	// ****************************************
	// Checks
	// ****************************************
	a_direct_ea: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(state == eatu_pkg::S_DEC && !indirect)
		|=> ar == $past(15'(ir[14:0] - (no_index ? 15'h0000 : sel_ir))))
		else $error("direct ea wrong");
	a_zero_index: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(state == eatu_pkg::S_DEC && !indirect && sel_ir == 15'h0000)
		|=> ar == $past(ir[14:0])) else $error("zero index changed base");
	a_ind_only_flags: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(state == eatu_pkg::S_DEC && !indirect) |=> state != eatu_pkg::S_IND)
		else $error("indirect without flags");
	a_ind_fetch_addr: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(state == eatu_pkg::S_DEC && indirect && op != eatu_pkg::OP_TSX)
		|=> mem_q.rd && mem_q.addr == $past(15'(ir[14:0] - (no_index ? 15'h0000 : sel_ir))))
		else $error("indirect location wrong");
	a_ind_final_ea: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(state == eatu_pkg::S_INDX) |=> sr[35:18] == 18'h00000 && ar == $past(15'(sr[14:0] -
		((sr[15] ? xr[0] : 15'h0000) | (sr[16] ? xr[1] : 15'h0000) | (sr[17] ? xr[2] : 15'h0000)))))
		else $error("indirect ea wrong");
	a_store_source: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(state == eatu_pkg::S_EXEC && op == eatu_pkg::OP_STXA && !indirect)
		|=> mem_q.wr && mem_q.addr == $past(ir[14:0]) && mem_q.wdata[14:0] == $past(
		(ir[15] ? xr[0] : 15'h0000) | (ir[16] ? xr[1] : 15'h0000) | (ir[17] ? xr[2] : 15'h0000)))
		else $error("index store wrong");
	a_one_level: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(state == eatu_pkg::S_INDX) |=> state == eatu_pkg::S_EXEC) else $error("indirect chained");
	a_ic_step: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(state == eatu_pkg::S_EXEC && op == eatu_pkg::OP_MEMREF && !reg_wr_in)
		|=> ic == 15'($past(ic) + 15'h0001) && ea_vld) else $error("counter not stepped");
	a_uncond_xfer: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(state == eatu_pkg::S_EXEC && op == eatu_pkg::OP_TRA && !reg_wr_in)
		|=> ic == $past(ar)) else $error("transfer lost");
	a_cond_xfer: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(state == eatu_pkg::S_EXEC && op == eatu_pkg::OP_TRC && !reg_wr_in)
		|=> ic == ($past(cond_in) ? $past(ar) : 15'($past(ic) + 15'h0001)))
		else $error("conditional transfer wrong");
	a_tsx_value: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(state == eatu_pkg::S_EXEC && op == eatu_pkg::OP_TSX)
		|=> ##2 index_input_buffer == 15'(15'h0000 - $past(ic, 3)))
		else $error("index not twos complement of counter");
endmodule : eatu_core
`default_nettype wire

// file: bench/eatu_mem_model.sv
// Core storage model for the effective address and transfer unit.
// Assumes one request at a time, held until the acknowledge is sampled.
`timescale 1ns/1ns
`default_nettype none
module eatu_mem_model #(
	parameter int SLOW = 3
) (
	input  wire logic                   clk_in,
	input  wire logic                   rstn_in,
	input  wire eatu_pkg::eatu_mem_req_t req_in,
	output logic                        ack_out,
	output logic      [35:0]            rdata_out
);
	// ****************************************
	// Storage and answer timing
	// ****************************************
	logic [35:0] words [0:32767];
	logic [35:0] last;
	int          cnt;
	logic        alt;

	// Prompt and slow answers alternate to vary the wait states
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ack_out   <= 1'b0;
			rdata_out <= 36'h000000000;
			last      <= 36'h000000000;
			cnt       <= 0;
			alt       <= 1'b0;
		end else begin
			ack_out   <= 1'b0;
			// Released data lines never keep showing the last word
			rdata_out <= ~last;
			if ((req_in.rd || req_in.wr) && !ack_out) begin
				if (cnt == (alt ? SLOW : 0)) begin
					ack_out <= 1'b1;
					cnt     <= 0;
					alt     <= ~alt;
					if (req_in.rd) begin
						rdata_out <= words[req_in.addr];
						last      <= words[req_in.addr];
					end
					if (req_in.wr)
						words[req_in.addr] <= req_in.wdata;
				end else begin
					cnt <= cnt + 1;
				end
			end
		end
	end
endmodule : eatu_mem_model
`default_nettype wire

// file: bench/eatu_core_bench.sv
// Self-checking bench for eatu_core: runs small programs from storage.
// Assumes the storage model above and the register map of the package.
`timescale 1ns/1ns
`default_nettype none
module eatu_core_bench;
	logic                    ref_clk_in;
	logic                    resetn_in;
	logic [7:0]              reg_addr_in;
	logic [31:0]             reg_wdata_in;
	logic                    reg_wr_in;
	logic                    reg_rd_in;
	logic [31:0]             reg_rdata_out;
	eatu_pkg::eatu_mem_req_t mem_req_out;
	logic                    mem_ack_in;
	logic [35:0]             mem_rdata_in;
	logic                    cond_in;
	logic [14:0]             ea_out;
	logic                    ea_valid_out;
	int                      error_cnt;
	int                      total_checks;
	logic [14:0]             ea_q[$];
	logic [31:0]             v;
	logic [14:0]             ea_exp [0:6];

	eatu_core DUT (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .mem_req_out(mem_req_out), .mem_ack_in(mem_ack_in),
		.mem_rdata_in(mem_rdata_in), .cond_in(cond_in), .ea_out(ea_out),
		.ea_valid_out(ea_valid_out));
	eatu_mem_model #(.SLOW(3)) mem (.clk_in(ref_clk_in), .rstn_in(resetn_in),
		.req_in(mem_req_out), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

	always #25 ref_clk_in = ~ref_clk_in;

	always @(posedge ref_clk_in) begin
		if (ea_valid_out === 1'b1)
			ea_q.push_back(ea_out);
	end

	// ****************************************
	// Bus tasks and checking
	// ****************************************
	function automatic logic [35:0] ins(logic [2:0] op, logic [1:0] ind, logic [2:0] tag,
			logic [14:0] base);
		return {op, 9'h000, ind, 4'h0, tag, base};
	endfunction : ins

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in    <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in   <= 1'b0;
		#1 d = reg_rdata_out;
	endtask : rd_reg

	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	// Bounded wait for the halt instruction to clear the run bit
	task automatic run_prog(input logic [14:0] start);
		int i;
		wr_reg(eatu_pkg::OFS_IC, {17'h00000, start});
		wr_reg(eatu_pkg::OFS_CTRL, 32'h00000001);
		for (i = 0; i < 400; i++) begin
			rd_reg(eatu_pkg::OFS_CTRL, v);
			if (v[0] === 1'b0)
				break;
		end
		if (i == 400) begin
			error_cnt++;
			summarize();
		end
	endtask : run_prog

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		ref_clk_in   = 1'b0;
		resetn_in    = 1'b0;
		reg_addr_in  = 8'h00;
		reg_wdata_in = 32'h00000000;
		reg_wr_in    = 1'b0;
		reg_rd_in    = 1'b0;
		cond_in      = 1'b0;
		error_cnt    = 0;
		total_checks = 0;
		ea_exp       = '{15'h0400, 15'h0400, 15'h03C0, 15'h03BD, 15'h7FD0, 15'h04FD, 15'h0200};
		mem.words[15'h0100] = ins(3'h0, 2'h0, 3'h0, 15'h0400);
		mem.words[15'h0101] = ins(3'h0, 2'h0, 3'h2, 15'h0400);
		mem.words[15'h0102] = ins(3'h0, 2'h0, 3'h1, 15'h0400);
		mem.words[15'h0103] = ins(3'h0, 2'h0, 3'h5, 15'h0400);
		mem.words[15'h0104] = ins(3'h0, 2'h0, 3'h1, 15'h0010);
		mem.words[15'h0105] = ins(3'h0, 2'h3, 3'h1, 15'h0240);
		mem.words[15'h0106] = ins(3'h0, 2'h2, 3'h0, 15'h0200);
		mem.words[15'h0107] = ins(3'h4, 2'h0, 3'h3, 15'h0300);
		mem.words[15'h0108] = ins(3'h5, 2'h0, 3'h4, 15'h0301);
		mem.words[15'h0109] = ins(3'h2, 2'h0, 3'h0, 15'h0150);
		mem.words[15'h010A] = ins(3'h1, 2'h0, 3'h0, 15'h0120);
		mem.words[15'h0120] = ins(3'h3, 2'h0, 3'h2, 15'h0130);
		mem.words[15'h0130] = ins(3'h6, 2'h0, 3'h0, 15'h0310);
		mem.words[15'h0311] = ins(3'h7, 2'h0, 3'h0, 15'h0000);
		mem.words[15'h0140] = ins(3'h2, 2'h0, 3'h0, 15'h0160);
		mem.words[15'h0160] = ins(3'h7, 2'h0, 3'h0, 15'h0000);
		// Indirect word with junk outside its address and tag fields
		mem.words[15'h0200] = {3'h7, 9'h1FF, 2'h3, 4'hF, 3'h4, 15'h0500};
		repeat (5) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		rd_reg(eatu_pkg::OFS_IC, v);
		check(36'(v), 36'h000000000);
		rd_reg(eatu_pkg::OFS_XR_BASE, v);
		check(36'(v), 36'h000000000);
		wr_reg(eatu_pkg::OFS_XR_BASE, 32'h00000040);
		wr_reg(8'h14, 32'h00000000);
		wr_reg(8'h18, 32'h00000003);
		run_prog(15'h0100);
		check(36'(ea_q.size()), 36'h000000007);
		if (ea_q.size() < 7) begin
			error_cnt++;
		end else begin
			foreach (ea_exp[i])
				check(36'(ea_q[i]), 36'(ea_exp[i]));
		end
		check(mem.words[15'h0300], 36'h000000040);
		check(mem.words[15'h0301], 36'h0000C0000);
		check(mem.words[15'h0310], 36'h000000131);
		rd_reg(eatu_pkg::OFS_IC, v);
		check(36'(v), 36'h000000312);
		rd_reg(8'h14, v);
		check(36'(v), 36'h000007EE0);
		rd_reg(eatu_pkg::OFS_XR_BASE, v);
		check(36'(v), 36'h000000040);
		rd_reg(eatu_pkg::OFS_STATUS, v);
		check(36'(v), 36'h000000000);
		rd_reg(eatu_pkg::OFS_EA, v);
		check(36'(v), 36'h000000200);
		rd_reg(8'h1C, v);
		check(36'(v), 36'h000000000);
		cond_in <= 1'b1;
		run_prog(15'h0140);
		rd_reg(eatu_pkg::OFS_IC, v);
		check(36'(v), 36'h000000161);
		summarize();
	end
endmodule : eatu_core_bench
`default_nettype wire
